/* pkg/sis_params.svh */
// offsets, field positions, reset values and defaults of the sensor irq block
`ifndef SIS_PARAMS_SVH
`define SIS_PARAMS_SVH

// register offsets
`define SIS_OFF_PART_IDENTITY 8'h00
`define SIS_OFF_SILICON_REV 8'h01
`define SIS_OFF_FIRMWARE_REV 8'h02
`define SIS_OFF_INT_CONFIG 8'h03
`define SIS_OFF_SRC_ENABLE 8'h04
`define SIS_OFF_FLAGS 8'h21
`define SIS_OFF_VIS_LOW 8'h22
`define SIS_OFF_VIS_HIGH 8'h23
`define SIS_OFF_IR_LOW 8'h24
`define SIS_OFF_IR_HIGH 8'h25
`define SIS_OFF_PROX1_LOW 8'h26
`define SIS_OFF_PROX1_HIGH 8'h27
`define SIS_OFF_PROX2_LOW 8'h28
`define SIS_OFF_PROX2_HIGH 8'h29
`define SIS_OFF_PROX3_LOW 8'h2a
`define SIS_OFF_PROX3_HIGH 8'h2b
`define SIS_OFF_AUX_LOW 8'h2c
`define SIS_OFF_AUX_HIGH 8'h2d
`define SIS_OFF_PARAM_READ 8'h2e
`define SIS_OFF_CHIP_STATE 8'h30
`define SIS_OFF_KEY_FIRST 8'h3b
`define SIS_OFF_KEY_LAST 8'h3e

// field positions
`define SIS_CFG_OE_BIT 0
`define SIS_CFG_MODE_BIT 1
`define SIS_BIT_AMB_LOW 0
`define SIS_BIT_AMB_HIGH 1
`define SIS_BIT_PROX1 2
`define SIS_BIT_PROX2 3
`define SIS_BIT_PROX3 4
`define SIS_BIT_CMD 5

// reset values
`define SIS_RST_INT_CONFIG 2'h0
`define SIS_RST_SRC_ENABLE 6'h00
`define SIS_RST_FLAGS 6'h00
`define SIS_RST_KEY 8'h00

// proximity condition that tracks the threshold level
`define SIS_PROX_MODE_ABOVE 2'h3

// default bus address and identity values (arbitrary)
`define SIS_I2C_ADDR 7'h2c
`define SIS_PART_IDENTITY 8'h5c
`define SIS_SILICON_REV 8'h07
`define SIS_FW_MAJOR 5'h02
`define SIS_FW_MINOR 3'h5

`endif

/* pkg/sis_pkg.sv */
// types shared by the sensor irq block
package sis_pkg;
    typedef enum logic [2:0] {
        SIS_ST_IDLE,
        SIS_ST_ADDR,
        SIS_ST_ACK_ADDR,
        SIS_ST_WRITE,
        SIS_ST_ACK_WR,
        SIS_ST_READ,
        SIS_ST_ACK_RD
    } sis_i2c_state_t;
endpackage

/* verification/sis_host_model.sv */
// i2c host model driving clock and data of the register bus
`timescale 1ns/1ps
`include "sis_params.svh"
module sis_host_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    int stretch;
    // clock stands high and data is released outside frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        stretch = 0;
    end
    // start or repeated start: data falls while clock high
    task automatic start();
        #80 sda_low = 1'b0;
        #40 scl = 1'b1;
        #80 sda_low = 1'b1;
        #80 scl = 1'b0;
    endtask
    // stop: data rises while clock high
    task automatic stop();
        #40 sda_low = 1'b1;
        #80 scl = 1'b1;
        #80 sda_low = 1'b0;
        #80;
    endtask
    // one bit: low phase of 120 ns or more, high phase 40 ns
    task automatic bit_io(input logic b, output logic r);
        #(40 + stretch) sda_low = !b;
        #80 scl = 1'b1;
        #40 r = sda;
        scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack_in,
        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ack_in, ack);
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d,
        output logic nak);
        logic [7:0] q;
        logic k0, k1, k2;
        start();
        xfer({`SIS_I2C_ADDR, 1'b0}, 1'b1, q, k0);
        xfer(a, 1'b1, q, k1);
        xfer(d, 1'b1, q, k2);
        stop();
        nak = k0 | k1 | k2;
    endtask
    // read one byte; host nack ends the read
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d,
        output logic nak);
        logic [7:0] q;
        logic k0, k1, k2, k3;
        start();
        xfer({`SIS_I2C_ADDR, 1'b0}, 1'b1, q, k0);
        xfer(a, 1'b1, q, k1);
        start();
        xfer({`SIS_I2C_ADDR, 1'b1}, 1'b1, q, k2);
        xfer(8'hff, 1'b1, d, k3);
        stop();
        nak = k0 | k1 | k2;
    endtask
endmodule

/* verification/sis_irq_regs_props.sv */
// assertions on the pins of the sensor irq block
`timescale 1ns/1ps
module sis_irq_regs_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic int_out,
    input wire logic int_oe,
    input wire logic cmd_event,
    input wire logic [2:0] prox_event,
    input wire logic [1:0] ambient_event,
    input wire logic [2:0] prox_above
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic scl_reg;
    logic [3:0] quiet_reg;
    logic quiet_ok;
    logic any_ev;
    // count edges since the bus clock last moved
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_reg <= 1'b1;
            quiet_reg <= 4'h0;
        end else begin
            scl_reg <= scl_in;
            if (scl_in != scl_reg) begin
                quiet_reg <= 4'h0;
            end else if (quiet_reg != 4'hf) begin
                quiet_reg <= quiet_reg + 4'h1;
            end
        end
    end
    // quiet bus: no register write can be in flight
    assign quiet_ok = quiet_reg >= 4'ha;
    assign any_ev = cmd_event | (|prox_event) | (|ambient_event);
    sequence pin_rise_s;
        quiet_ok && !int_oe ##1 int_oe;
    endsequence
    sequence pin_fall_s;
        quiet_ok && int_oe ##1 !int_oe;
    endsequence
    irq_value_low_a: assert property (int_out == 1'b0)
        else $error("irq pin value not low");
    sda_value_low_a: assert property (sda_out == 1'b0)
        else $error("data pin value not low");
    irq_rise_cause_a: assert property (
        pin_rise_s |-> $past(any_ev, 2))
        else $error("irq pin rose without a flag event");
    irq_fall_cause_a: assert property (
        pin_fall_s |-> $past(prox_above, 2) != 3'h7)
        else $error("irq pin fell without host or auto clear");
    sticky_hold_a: assert property (
        int_oe && quiet_ok && prox_above == 3'h7 |=> int_oe)
        else $error("irq pin withdrawn on its own");
    sda_low_phase_a: assert property (
        $changed(sda_oe) |-> !scl_in && !$past(scl_in, 3))
        else $error("data drive moved outside clock low");
    sda_high_hold_a: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data drive moved while clock high");
    sda_idle_hold_a: assert property (quiet_ok |-> $stable(sda_oe))
        else $error("data drive moved on an idle bus");
endmodule

bind sis_irq_regs sis_irq_regs_props sis_irq_regs_props_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .scl_in(scl_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .int_out(int_out),
    .int_oe(int_oe),
    .cmd_event(cmd_event),
    .prox_event(prox_event),
    .ambient_event(ambient_event),
    .prox_above(prox_above)
);

/* verification/sis_irq_regs_tb.sv */
// self-checking bench of the sensor irq block
`timescale 1ns/1ps
`include "sis_params.svh"
module sis_irq_regs_tb;
    logic clk;
    logic sys_rst;
    logic cmd_event;
    logic [2:0] prox_event;
    logic [1:0] ambient_event;
    logic [2:0] prox_above;
    logic [5:0] prox_irq_condition;
    logic [15:0] res [6];
    logic [7:0] param_value;
    logic [2:0] chip_state_bits;
    logic sda_out, sda_oe, int_out, int_oe;
    logic scl_w, host_low;
    logic sda_w;
    logic [31:0] seed;
    int n_fail;
    int num_checks;
    // open-drain data line with pull-up
    assign sda_w = !(host_low || sda_oe);
    sis_host_model sis_host_model_inst (.scl(scl_w), .sda_low(host_low),
        .sda(sda_w));
    sis_irq_regs sis_irq_regs_inst (.clk(clk), .sys_rst(sys_rst),
        .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe),
        .cmd_event(cmd_event), .prox_event(prox_event),
        .ambient_event(ambient_event), .prox_above(prox_above),
        .prox_irq_condition(prox_irq_condition),
        .visible_light(res[0]), .infrared_light(res[1]),
        .prox_one(res[2]), .prox_two(res[3]), .prox_three(res[4]),
        .aux_result(res[5]), .param_value(param_value),
        .chip_state_bits(chip_state_bits));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected byte of a result, parameter or state place
    function automatic logic [7:0] exp_byte(input logic [7:0] a);
        logic [15:0] w;
        if (a == `SIS_OFF_PARAM_READ) return param_value;
        if (a == `SIS_OFF_CHIP_STATE) return {5'h00, chip_state_bits};
        w = res[3'((a - 8'h22) >> 1)];
        return a[0] ? w[15:8] : w[7:0];
    endfunction
    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic nak;
        sis_host_model_inst.reg_write(a, d, nak);
        chk("write ack", 8'h00, {7'h00, nak});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic nak;
        sis_host_model_inst.reg_read(a, d, nak);
        chk("read ack", 8'h00, {7'h00, nak});
        chk($sformatf("register %h", a), exp, d);
    endtask
    task automatic pin(input logic exp);
        chk("irq drive", {7'h00, exp}, {7'h00, int_oe});
    endtask
    // one-cycle sequencer pulse on flag source b
    task automatic pulse(input int b);
        @(negedge clk);
        {cmd_event, prox_event, ambient_event} = 6'(1 << b);
        @(negedge clk);
        {cmd_event, prox_event, ambient_event} = 6'h00;
        repeat (3) @(negedge clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #1000000;
        n_fail++;
        conclude();
    end
    initial begin
        logic [7:0] en;
        seed = 32'd61247;
        n_fail = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        {cmd_event, prox_event, ambient_event} = 6'h00;
        prox_above = 3'h7;
        prox_irq_condition = 6'h00;
        for (int i = 0; i < 6; i++) res[i] = 16'(xs());
        param_value = 8'(xs());
        chip_state_bits = 3'(xs());
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        // reset values, identity, read-only and unmapped places
        rd(`SIS_OFF_INT_CONFIG, 8'h00);
        rd(`SIS_OFF_SRC_ENABLE, 8'h00);
        rd(`SIS_OFF_FLAGS, 8'h00);
        rd(`SIS_OFF_PART_IDENTITY, `SIS_PART_IDENTITY);
        rd(`SIS_OFF_SILICON_REV, `SIS_SILICON_REV);
        wr(`SIS_OFF_FIRMWARE_REV, 8'hff);
        rd(`SIS_OFF_FIRMWARE_REV, {`SIS_FW_MAJOR, `SIS_FW_MINOR});
        rd(8'h10, 8'h00);
        en = 8'(xs());
        wr(`SIS_OFF_KEY_FIRST, en);
        rd(`SIS_OFF_KEY_FIRST, en);
        wr(`SIS_OFF_INT_CONFIG, 8'hff);
        rd(`SIS_OFF_INT_CONFIG, 8'h03);
        wr(`SIS_OFF_INT_CONFIG, 8'h01);
        // each source with random enables, its own bit forced on then off
        for (int k = 0; k < 12; k++) begin
            en = 8'(xs() & 32'h3f);
            en[k % 6] = (k < 6);
            wr(`SIS_OFF_SRC_ENABLE, en);
            pulse(k % 6);
            pin(en[k % 6]);
            wr(`SIS_OFF_FLAGS, 8'h00);
            rd(`SIS_OFF_FLAGS, 8'(1 << (k % 6)));
            wr(`SIS_OFF_FLAGS, 8'(1 << (k % 6)));
            rd(`SIS_OFF_FLAGS, 8'h00);
            pin(1'b0);
        end
        rd(`SIS_OFF_SRC_ENABLE, en);
        // output disabled: flags collect but the pin stays free
        wr(`SIS_OFF_INT_CONFIG, 8'h00);
        wr(`SIS_OFF_SRC_ENABLE, 8'h3f);
        for (int b = 0; b < 6; b++) pulse(b);
        pin(1'b0);
        rd(`SIS_OFF_FLAGS, 8'h3f);
        wr(`SIS_OFF_INT_CONFIG, 8'h01);
        pin(1'b1);
        wr(`SIS_OFF_FLAGS, 8'h3f);
        pin(1'b0);
        // clear mode and condition: only mode 1 with condition 11 drops
        for (int m = 0; m < 4; m++) begin
            prox_irq_condition = {3{m[0] ? 2'h3 : 2'h1}};
            wr(`SIS_OFF_INT_CONFIG, {6'h00, m[1], 1'b1});
            pulse(2 + m % 3);
            prox_above[m % 3] = 1'b0;
            repeat (4) @(negedge clk);
            pin(!(m[1] && m[0]));
            wr(`SIS_OFF_FLAGS, 8'h3f);
            prox_above = 3'h7;
        end
        // results read byte by byte by a slow host
        sis_host_model_inst.stretch = 60;
        for (int a = 8'h22; a <= 8'h2e; a++) begin
            rd(8'(a), exp_byte(8'(a)));
        end
        rd(`SIS_OFF_CHIP_STATE, exp_byte(`SIS_OFF_CHIP_STATE));
        conclude();
    end
endmodule

/* verilog/sis_irq_regs.sv */
// interrupt status, enable, pin logic and i2c register map of the sensor
`timescale 1ns/1ps
`include "sis_params.svh"
module sis_irq_regs
    import sis_pkg::*;
#(
    parameter logic [6:0] I2C_ADDR = `SIS_I2C_ADDR,
    parameter logic [7:0] PART_IDENTITY = `SIS_PART_IDENTITY,
    parameter logic [7:0] SILICON_REV = `SIS_SILICON_REV,
    parameter logic [4:0] FW_MAJOR = `SIS_FW_MAJOR,
    parameter logic [2:0] FW_MINOR = `SIS_FW_MINOR
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic int_out,
    output logic int_oe,
    input wire logic cmd_event,
    input wire logic [2:0] prox_event,
    input wire logic [1:0] ambient_event,
    input wire logic [2:0] prox_above,
    input wire logic [5:0] prox_irq_condition,
    input wire logic [15:0] visible_light,
    input wire logic [15:0] infrared_light,
    input wire logic [15:0] prox_one,
    input wire logic [15:0] prox_two,
    input wire logic [15:0] prox_three,
    input wire logic [15:0] aux_result,
    input wire logic [7:0] param_value,
    input wire logic [2:0] chip_state_bits
);
    // synchronised bus pins and their previous values
    logic [1:0] pins_sync;
    logic scl_s;
    logic sda_s;
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // bus engine state
    sis_i2c_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] ptr_reg;
    logic rw_reg;
    logic first_reg;
    logic nack_reg;
    logic wr_stb_reg;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_data_reg;
    logic [7:0] rd_byte;

    // register state
    logic [1:0] int_config_reg;
    logic [5:0] src_enable_reg;
    logic [5:0] flags_reg;
    logic [5:0] flags_next;
    logic [7:0] key_reg [0:3];
    logic [7:0] fw_rev;
    logic [5:0] set_vec;
    logic [5:0] clr_vec;
    logic [5:0] auto_drop;
    logic [5:0] match;
    logic [1:0] key_idx;

    sis_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in({scl_in, sda_in}),
        .sync_out(pins_sync)
    );

    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];

    // previous pin values for edge and condition detection
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // bus edges, start and stop conditions
    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign start_seen = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_seen = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // firmware revision: major in upper bits, minor in lower three
    assign fw_rev = {FW_MAJOR, FW_MINOR};

    // read data for the current pointer
    always_comb begin
        rd_byte = 8'h00;
        if (ptr_reg == `SIS_OFF_PART_IDENTITY) begin
            rd_byte = PART_IDENTITY;
        end else if (ptr_reg == `SIS_OFF_SILICON_REV) begin
            rd_byte = SILICON_REV;
        end else if (ptr_reg == `SIS_OFF_FIRMWARE_REV) begin
            rd_byte = fw_rev;
        end else if (ptr_reg == `SIS_OFF_INT_CONFIG) begin
            rd_byte = {6'h00, int_config_reg};
        end else if (ptr_reg == `SIS_OFF_SRC_ENABLE) begin
            rd_byte = {2'h0, src_enable_reg};
        end else if (ptr_reg == `SIS_OFF_FLAGS) begin
            rd_byte = {2'h0, flags_reg};
        end else if (ptr_reg == `SIS_OFF_VIS_LOW) begin
            rd_byte = visible_light[7:0];
        end else if (ptr_reg == `SIS_OFF_VIS_HIGH) begin
            rd_byte = visible_light[15:8];
        end else if (ptr_reg == `SIS_OFF_IR_LOW) begin
            rd_byte = infrared_light[7:0];
        end else if (ptr_reg == `SIS_OFF_IR_HIGH) begin
            rd_byte = infrared_light[15:8];
        end else if (ptr_reg == `SIS_OFF_PROX1_LOW) begin
            rd_byte = prox_one[7:0];
        end else if (ptr_reg == `SIS_OFF_PROX1_HIGH) begin
            rd_byte = prox_one[15:8];
        end else if (ptr_reg == `SIS_OFF_PROX2_LOW) begin
            rd_byte = prox_two[7:0];
        end else if (ptr_reg == `SIS_OFF_PROX2_HIGH) begin
            rd_byte = prox_two[15:8];
        end else if (ptr_reg == `SIS_OFF_PROX3_LOW) begin
            rd_byte = prox_three[7:0];
        end else if (ptr_reg == `SIS_OFF_PROX3_HIGH) begin
            rd_byte = prox_three[15:8];
        end else if (ptr_reg == `SIS_OFF_AUX_LOW) begin
            rd_byte = aux_result[7:0];
        end else if (ptr_reg == `SIS_OFF_AUX_HIGH) begin
            rd_byte = aux_result[15:8];
        end else if (ptr_reg == `SIS_OFF_PARAM_READ) begin
            rd_byte = param_value;
        end else if (ptr_reg == `SIS_OFF_CHIP_STATE) begin
            rd_byte = {5'h00, chip_state_bits};
        end else if (ptr_reg >= `SIS_OFF_KEY_FIRST &&
                     ptr_reg <= `SIS_OFF_KEY_LAST) begin
            rd_byte = key_reg[ptr_reg[1:0] - 2'h3];
        end
    end

    // i2c slave: address, pointer byte, writes and auto-increment reads
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= SIS_ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            nack_reg <= 1'b0;
            sda_oe <= 1'b0;
            wr_stb_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
        end else begin
            wr_stb_reg <= 1'b0;
            if (stop_seen) begin
                state_reg <= SIS_ST_IDLE;
                sda_oe <= 1'b0;
            end else if (start_seen) begin
                state_reg <= SIS_ST_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_oe <= 1'b0;
            end else begin
                case (state_reg)
                    SIS_ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    SIS_ST_ADDR: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            if (shift_reg[7:1] == I2C_ADDR) begin
                                rw_reg <= shift_reg[0];
                                sda_oe <= 1'b1; // acknowledge
                                state_reg <= SIS_ST_ACK_ADDR;
                            end else begin
                                state_reg <= SIS_ST_IDLE;
                            end
                        end
                    end
                    SIS_ST_ACK_ADDR: begin
                        if (scl_fall) begin
                            bit_cnt_reg <= 4'h0;
                            if (rw_reg) begin
                                shift_reg <= rd_byte;
                                ptr_reg <= ptr_reg + 8'h01;
                                sda_oe <= ~rd_byte[7];
                                state_reg <= SIS_ST_READ;
                            end else begin
                                sda_oe <= 1'b0;
                                first_reg <= 1'b1;
                                state_reg <= SIS_ST_WRITE;
                            end
                        end
                    end
                    SIS_ST_WRITE: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            if (first_reg) begin
                                ptr_reg <= shift_reg; // pointer byte
                                first_reg <= 1'b0;
                            end else begin
                                wr_stb_reg <= 1'b1;
                                wr_addr_reg <= ptr_reg;
                                wr_data_reg <= shift_reg;
                                ptr_reg <= ptr_reg + 8'h01;
                            end
                            sda_oe <= 1'b1;
                            state_reg <= SIS_ST_ACK_WR;
                        end
                    end
                    SIS_ST_ACK_WR: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            bit_cnt_reg <= 4'h0;
                            state_reg <= SIS_ST_WRITE;
                        end
                    end
                    SIS_ST_READ: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == 4'h7) begin
                                sda_oe <= 1'b0; // let host acknowledge
                                bit_cnt_reg <= 4'h0;
                                state_reg <= SIS_ST_ACK_RD;
                            end else begin
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                sda_oe <= ~shift_reg[6];
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    SIS_ST_ACK_RD: begin
                        if (scl_rise) begin
                            nack_reg <= sda_s;
                        end else if (scl_fall) begin
                            if (nack_reg) begin
                                state_reg <= SIS_ST_IDLE;
                            end else begin
                                shift_reg <= rd_byte;
                                ptr_reg <= ptr_reg + 8'h01;
                                sda_oe <= ~rd_byte[7];
                                bit_cnt_reg <= 4'h0;
                                state_reg <= SIS_ST_READ;
                            end
                        end
                    end
                    default: begin
                        state_reg <= SIS_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // open-drain lines only ever pull low
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_out <= 1'b0;
            int_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            int_out <= 1'b0;
        end
    end

    // interrupt configuration: output enable and clear mode
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_config_reg <= `SIS_RST_INT_CONFIG;
        end else if (wr_stb_reg && wr_addr_reg == `SIS_OFF_INT_CONFIG) begin
            int_config_reg <= wr_data_reg[1:0];
        end
    end

    // source enable register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            src_enable_reg <= `SIS_RST_SRC_ENABLE;
        end else if (wr_stb_reg && wr_addr_reg == `SIS_OFF_SRC_ENABLE) begin
            src_enable_reg <= wr_data_reg[5:0];
        end
    end

    // analog key bytes, plain storage
    assign key_idx = wr_addr_reg[1:0] - 2'h3;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int k = 0; k < 4; k++) begin
                key_reg[k] <= `SIS_RST_KEY;
            end
        end else if (wr_stb_reg && wr_addr_reg >= `SIS_OFF_KEY_FIRST &&
                     wr_addr_reg <= `SIS_OFF_KEY_LAST) begin
            key_reg[key_idx] <= wr_data_reg;
        end
    end

    // sequencer events and host clears for each flag
    assign set_vec = {cmd_event, prox_event, ambient_event};
    assign clr_vec = (wr_stb_reg && wr_addr_reg == `SIS_OFF_FLAGS) ?
                     wr_data_reg[5:0] : 6'h00;

    // self-clear of proximity flags in level mode below threshold
    assign auto_drop[`SIS_BIT_AMB_LOW] = 1'b0;
    assign auto_drop[`SIS_BIT_AMB_HIGH] = 1'b0;
    assign auto_drop[`SIS_BIT_CMD] = 1'b0;
    genvar c;
    generate
        for (c = 0; c < 3; c++) begin : g_prox
            assign auto_drop[`SIS_BIT_PROX1 + c] =
                int_config_reg[`SIS_CFG_MODE_BIT] &&
                prox_irq_condition[2*c+1 -: 2] == `SIS_PROX_MODE_ABOVE &&
                !prox_above[c];
        end
    endgenerate

    // next flag value: a set in the clearing cycle wins
    genvar f;
    generate
        for (f = 0; f < 6; f++) begin : g_flag
            assign flags_next[f] = set_vec[f] |
                (flags_reg[f] & ~clr_vec[f] & ~auto_drop[f]);
        end
    endgenerate

    // sticky flag register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_reg <= `SIS_RST_FLAGS;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // flag and enable pairs that may pull the pin
    assign match[`SIS_BIT_CMD] = flags_reg[`SIS_BIT_CMD] &
                                 src_enable_reg[`SIS_BIT_CMD];
    assign match[`SIS_BIT_PROX3] = flags_reg[`SIS_BIT_PROX3] &
                                   src_enable_reg[`SIS_BIT_PROX3];
    assign match[`SIS_BIT_PROX2] = flags_reg[`SIS_BIT_PROX2] &
                                   src_enable_reg[`SIS_BIT_PROX2];
    assign match[`SIS_BIT_PROX1] = flags_reg[`SIS_BIT_PROX1] &
                                   src_enable_reg[`SIS_BIT_PROX1];
    assign match[`SIS_BIT_AMB_HIGH] = flags_reg[`SIS_BIT_AMB_HIGH] &
        src_enable_reg[`SIS_BIT_AMB_HIGH];
    assign match[`SIS_BIT_AMB_LOW] = flags_reg[`SIS_BIT_AMB_LOW] &
        src_enable_reg[`SIS_BIT_AMB_LOW];

    // interrupt pin drive: pulled low only when enabled and a pair matches
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_oe <= 1'b0;
        end else begin
            int_oe <= int_config_reg[`SIS_CFG_OE_BIT] & (|match);
        end
    end
endmodule

/* verilog/sis_sync2.sv */
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module sis_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_reg;
            // first stage feeds only the second; idle level of the bus is high
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    meta_reg <= 1'b1;
                    sync_out[i] <= 1'b1;
                end else begin
                    meta_reg <= async_in[i];
                    sync_out[i] <= meta_reg;
                end
            end
        end
    endgenerate
endmodule
